// [verilog/tap_pkg.sv]
// Shared constants and types for the test access port and its controller.
package tap_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and instruction codes.
  localparam int IR_W = 4; // Instruction register width.
  localparam int DR_W = 32; // Widest data register.
  localparam logic [3:0] IR_CAPTURE = 4'h1; // Fixed value captured into IR.
  localparam logic [3:0] INS_EXTEST = 4'h0;
  localparam logic [3:0] INS_IDCODE = 4'h1;
  localparam logic [3:0] INS_SAMPLE = 4'h2;
  localparam logic [3:0] INS_PROG = 4'h4;
  localparam logic [3:0] INS_PRIV_LO = 4'h8; // First private debug code.
  localparam logic [3:0] INS_PRIV_HI = 4'hB; // Last private debug code.
  localparam logic [3:0] INS_BYPASS = 4'hF;
  localparam logic [3:0] INS_RESET_VAL = INS_IDCODE; // Instruction after reset.
  // Identification value; the value is arbitrary.
  localparam logic [31:0] ID_VALUE = 32'h1234_5671;

  ////////////////////////////////////////////////////////////////////////////
  // Chain lengths.
  localparam logic [5:0] LEN_ID = 6'h20;
  localparam logic [5:0] LEN_BYP = 6'h01;
  localparam logic [5:0] LEN_BSC = 6'h08;
  localparam logic [5:0] LEN_PROG = 6'h10;
  localparam logic [5:0] LEN_DBG = 6'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Controller-side timing and TMS walks (bits sent first in bit 0).
  localparam int CLK_PERIOD_NS = 50;
  localparam int TCK_PERIOD_NS = 400;
  localparam int TCK_HALF = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [2:0] DIV_HIGH = 3'(TCK_HALF); // First high-phase count.
  localparam logic [2:0] DIV_LAST = 3'(2 * TCK_HALF - 1); // Last count of a bit.
  localparam logic [5:0] PRE_IR = 6'h03; // 1,1,0,0 from idle.
  localparam logic [2:0] PRE_IR_N = 3'h4;
  localparam logic [5:0] PRE_DR = 6'h01; // 1,0,0 from idle.
  localparam logic [2:0] PRE_DR_N = 3'h3;
  localparam logic [5:0] PRE_RST = 6'h1F; // 1,1,1,1,1 then 0 to idle.
  localparam logic [2:0] PRE_RST_N = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [1:0] {OP_RESET, OP_IR, OP_DR} tap_op_e;
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
    ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } tap_state_e;
  typedef enum logic [2:0] {CH_BYP, CH_ID, CH_BSC, CH_PROG, CH_ISCAN, CH_BRK} tap_chain_e;

  // Shift right, entering the new bit at the top of a chain of given length.
  function automatic logic [31:0] tap_shift(logic [31:0] d, logic b, logic [5:0] len);
    logic [31:0] r;
    r = d >> 1;
    r[5'(len - 6'h01)] = b;
    return r;
  endfunction

endpackage

// [verilog/tap_link_if.sv]
// Four-wire test link plus the shared system reset line.
`timescale 1ns/1ps
interface tap_link_if;
  logic tck; // Test clock, made by the controller.
  logic tms; // Mode select.
  logic tdi; // Serial data towards the device.
  logic tdo_o; // Device data out.
  logic tdo_oe; // Device drives tdo.
  logic pull_en; // Device pull-ups on its test inputs.
  logic host_rst_oe; // Controller pulls the reset line low.
  logic dev_rst_oe; // Device system pulls the reset line low.
  logic tdo; // Resolved tdo; a released pin floats high.
  logic sys_rst_n; // Resolved open-drain reset line.

  assign tdo = tdo_oe ? tdo_o : 1'h1;
  assign sys_rst_n = ~(host_rst_oe | dev_rst_oe);

  modport dev(input tck, input tms, input tdi, input sys_rst_n, output tdo_o,
              output tdo_oe, output pull_en, output dev_rst_oe);
  modport host(output tck, output tms, output tdi, output host_rst_oe, input tdo,
               input sys_rst_n, input pull_en);
endinterface // tap_link_if

// [verilog/tap_sync3.sv]
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module tap_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg; // Stages and accepted value.
  logic [W-1:0] q_next;

  ////////////////////////////////////////////////////////////////////////////
  // Only stage two and three are compared; stage one feeds nothing else.
  always_comb begin
    q_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (q_reg & (s2_reg ^ s3_reg));
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule // tap_sync3

// [verilog/tap_device.sv]
// Device end: test access port state machine, instruction and data chains.
`timescale 1ns/1ps

module tap_device (
  input wire logic arst_n,
  tap_link_if.dev link,
  input wire logic test_port_enable_fuse,
  input wire logic test_port_disable_bit,
  input wire logic debug_enable_fuse,
  input wire logic [7:0] bsc_in,
  output logic [7:0] bsc_out,
  input wire logic [15:0] prog_in,
  output logic [15:0] prog_out,
  input wire logic [7:0] iscan_in,
  output logic [7:0] iscan_out,
  input wire logic [7:0] brk_in,
  output logic [7:0] brk_out,
  output logic [3:0] instr,
  output logic run_idle,
  output logic port_active,
  output logic pin_tms,
  output logic pin_tdi,
  input wire logic gpio_tdo_out,
  input wire logic gpio_tdo_oe,
  input wire logic sys_reset_drive
);
  import tap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State.
  tap_state_e st_reg, st_next; // Controller state.
  logic [3:0] ir_sh_reg, ir_sh_next; // Instruction shift stage.
  logic [3:0] ir_reg, ir_next; // Current instruction.
  logic [31:0] dr_reg, dr_next; // Shared data shift stage.
  logic [7:0] bsc_reg, bsc_next; // Boundary outputs.
  logic [15:0] prog_reg, prog_next; // Programming interface outputs.
  logic [7:0] iscan_reg, iscan_next; // Internal scan outputs.
  logic [7:0] brk_reg, brk_next; // Breakpoint scan outputs.
  logic tdo_reg, tdo_next; // Falling-edge data out.
  logic oe_reg, oe_next; // Falling-edge output enable.
  logic [2:0] straps; // Synchronised fuses and disable bit.
  tap_chain_e chain; // Chain picked by the instruction.
  logic [5:0] len; // Length of that chain.

  ////////////////////////////////////////////////////////////////////////////
  // Step the controller; the diagram itself makes five high TMS reach reset.
  function automatic tap_state_e tap_step(tap_state_e s, logic m);
    case (s)
      ST_RESET: return m ? ST_RESET : ST_IDLE;
      ST_IDLE: return m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: return m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: return m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: return m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: return m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: return m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: return m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: return m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: return m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: return m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: return m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: return m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: return m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: return m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: return m ? ST_SEL_DR : ST_IDLE;
      default: return ST_RESET;
    endcase
  endfunction

  // Map an instruction to a chain; private codes fall back to bypass
  // when the debug fuse is off, so a locked part shows nothing.
  function automatic tap_chain_e tap_pick(logic [3:0] ir, logic dbg);
    if (ir == INS_EXTEST || ir == INS_SAMPLE) begin
      return CH_BSC;
    end else if (ir == INS_IDCODE) begin
      return CH_ID;
    end else if (ir == INS_PROG) begin
      return CH_PROG;
    end else if (dbg && ir >= INS_PRIV_LO && ir <= INS_PRIV_HI) begin
      return ir[1] ? CH_BRK : CH_ISCAN;
    end else begin
      return CH_BYP;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Fuses and disable bit come from the system side, so they cross on TCK.
  // Limitation: a change needs four TCK edges before it takes effect.
  tap_sync3 #(.W(3)) u_sync (
    .clk(link.tck),
    .arst_n(arst_n),
    .d({debug_enable_fuse, test_port_disable_bit, test_port_enable_fuse}),
    .q(straps)
  );

  assign port_active = straps[0] & ~straps[1];
  assign chain = tap_pick(ir_reg, straps[2]);
  always_comb begin
    case (chain)
      CH_ID: len = LEN_ID;
      CH_BSC: len = LEN_BSC;
      CH_PROG: len = LEN_PROG;
      CH_ISCAN: len = LEN_DBG;
      CH_BRK: len = LEN_DBG;
      default: len = LEN_BYP;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values on the rising TCK edge. Every action occurs on the edge
  // that leaves the named state; exit and pause states keep everything.
  always_comb begin
    st_next = port_active ? tap_step(st_reg, link.tms) : ST_RESET;
    ir_sh_next = ir_sh_reg;
    ir_next = ir_reg;
    dr_next = dr_reg;
    bsc_next = bsc_reg;
    prog_next = prog_reg;
    iscan_next = iscan_reg;
    brk_next = brk_reg;
    case (st_reg)
      ST_RESET: begin
        ir_next = INS_RESET_VAL;
      end
      ST_CAP_IR: begin
        ir_sh_next = IR_CAPTURE;
      end
      ST_SH_IR: begin
        // The last bit enters on the edge where TMS goes high.
        ir_sh_next = {link.tdi, ir_sh_reg[3:1]};
      end
      ST_UPD_IR: begin
        ir_next = ir_sh_reg;
      end
      ST_CAP_DR: begin
        case (chain)
          CH_ID: dr_next = ID_VALUE;
          CH_BSC: dr_next = {24'h00_0000, bsc_in};
          CH_PROG: dr_next = {16'h0000, prog_in};
          CH_ISCAN: dr_next = {24'h00_0000, iscan_in};
          CH_BRK: dr_next = {24'h00_0000, brk_in};
          default: dr_next = 32'h0000_0000;
        endcase
      end
      ST_SH_DR: begin
        dr_next = tap_shift(dr_reg, link.tdi, len);
      end
      ST_UPD_DR: begin
        // SAMPLE shares the boundary chain but never drives its outputs.
        case (chain)
          CH_BSC: bsc_next = (ir_reg == INS_EXTEST) ? dr_reg[7:0] : bsc_reg;
          CH_PROG: prog_next = dr_reg[15:0];
          CH_ISCAN: iscan_next = dr_reg[7:0];
          CH_BRK: brk_next = dr_reg[7:0];
          default: ;
        endcase
      end
      default: ;
    endcase
  end

  // Only the power-on reset acts asynchronously; there is no test reset pin.
  always_ff @(posedge link.tck or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= ST_RESET;
      ir_sh_reg <= IR_CAPTURE;
      ir_reg <= INS_RESET_VAL;
      dr_reg <= 32'h0000_0000;
      bsc_reg <= 8'h00;
      prog_reg <= 16'h0000;
      iscan_reg <= 8'h00;
      brk_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      ir_sh_reg <= ir_sh_next;
      ir_reg <= ir_next;
      dr_reg <= dr_next;
      bsc_reg <= bsc_next;
      prog_reg <= prog_next;
      iscan_reg <= iscan_next;
      brk_reg <= brk_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage on the falling edge, a full period ahead of the
  // controller's sample, so set-up at the far end is generous.
  always_comb begin
    oe_next = port_active && (st_reg == ST_SH_IR || st_reg == ST_SH_DR);
    tdo_next = (st_reg == ST_SH_IR) ? ir_sh_reg[0] : dr_reg[0];
  end

  always_ff @(negedge link.tck or negedge arst_n) begin
    if (!arst_n) begin
      tdo_reg <= 1'h0;
      oe_reg <= 1'h0;
    end else begin
      tdo_reg <= tdo_next;
      oe_reg <= oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins: a disabled port hands tdo back to general-purpose logic.
  assign link.tdo_o = port_active ? tdo_reg : gpio_tdo_out;
  assign link.tdo_oe = port_active ? oe_reg : gpio_tdo_oe;
  assign link.pull_en = straps[0];
  assign link.dev_rst_oe = sys_reset_drive;
  assign pin_tms = link.tms;
  assign pin_tdi = link.tdi;
  assign instr = ir_reg;
  assign run_idle = (st_reg == ST_IDLE);
  assign bsc_out = bsc_reg;
  assign prog_out = prog_reg;
  assign iscan_out = iscan_reg;
  assign brk_out = brk_reg;
endmodule // tap_device

// [verilog/tap_host.sv]
// Controller end: makes TCK by division and walks TMS for each command.
`timescale 1ns/1ps
module tap_host (
  input wire logic clk,
  input wire logic arst_n,
  tap_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire tap_pkg::tap_op_e cmd_op,
  input wire logic [5:0] cmd_len,
  input wire logic [31:0] cmd_data,
  output logic rsp_valid,
  output logic [31:0] rsp_data,
  input wire logic sys_rst_req,
  output logic sys_rst_seen
);
  import tap_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_PRE, H_SHIFT, H_POST} tap_hstate_e;

  ////////////////////////////////////////////////////////////////////////////
  // State.
  tap_hstate_e st_reg, st_next; // Walk phase.
  logic [2:0] div_reg, div_next; // Position inside one TCK period.
  logic tck_reg, tck_next; // Clock pin.
  logic tms_reg, tms_next; // Mode pin.
  logic tdi_reg, tdi_next; // Data pin.
  logic [5:0] pat_reg, pat_next; // TMS walk still to send.
  logic [2:0] cnt_reg, cnt_next; // Walk bits left.
  logic [5:0] len_reg, len_next; // Chain length.
  logic [5:0] left_reg, left_next; // Shift bits left.
  logic [31:0] sh_reg, sh_next; // Outgoing data, then answer.
  logic rst_op_reg, rst_op_next; // Command is a plain reset walk.
  logic rsp_reg, rsp_next; // Answer pulse.
  logic [31:0] rdat_reg, rdat_next; // Answer data.
  logic [1:0] ins; // Synchronised tdo and reset line.
  logic bit_end; // Last clock of a TCK period.

  ////////////////////////////////////////////////////////////////////////////
  // Pins from the device side cross four flops (three stages and the accepted value) before use.
  tap_sync3 #(.W(2)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({~link.sys_rst_n, link.tdo}),
    .q(ins)
  );

  assign bit_end = (div_reg == DIV_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Walk: new TMS and TDI at each falling edge, tdo taken just before it,
  // long after the device changed it on the previous falling edge.
  always_comb begin
    st_next = st_reg;
    div_next = (st_reg == H_IDLE) ? 3'h0 : div_reg + 3'h1;
    tms_next = tms_reg;
    tdi_next = tdi_reg;
    pat_next = pat_reg;
    cnt_next = cnt_reg;
    len_next = len_reg;
    left_next = left_reg;
    sh_next = sh_reg;
    rst_op_next = rst_op_reg;
    rsp_next = 1'h0;
    rdat_next = rdat_reg;
    case (st_reg)
      H_IDLE: begin
        if (cmd_valid) begin
          st_next = H_PRE;
          rst_op_next = (cmd_op == OP_RESET);
          len_next = (cmd_len == 6'h00) ? LEN_BYP : cmd_len;
          left_next = (cmd_len == 6'h00) ? LEN_BYP : cmd_len;
          sh_next = cmd_data;
          case (cmd_op)
            OP_IR: begin
              pat_next = PRE_IR;
              cnt_next = PRE_IR_N;
            end
            OP_DR: begin
              pat_next = PRE_DR;
              cnt_next = PRE_DR_N;
            end
            default: begin
              pat_next = PRE_RST;
              cnt_next = PRE_RST_N;
            end
          endcase
          tms_next = pat_next[0];
        end
      end
      H_PRE: begin
        if (bit_end) begin
          if (cnt_reg == 3'h1) begin
            st_next = rst_op_reg ? H_IDLE : H_SHIFT;
            tms_next = !rst_op_reg && (left_reg == 6'h01);
            tdi_next = sh_reg[0];
          end else begin
            pat_next = pat_reg >> 1;
            cnt_next = cnt_reg - 3'h1;
            tms_next = pat_next[0];
          end
        end
      end
      H_SHIFT: begin
        if (bit_end) begin
          sh_next = tap_shift(sh_reg, ins[0], len_reg);
          tdi_next = sh_next[0];
          left_next = left_reg - 6'h01;
          if (left_reg == 6'h01) begin
            st_next = H_POST;
            tms_next = 1'h1;
            cnt_next = 3'h2;
          end else begin
            tms_next = (left_reg == 6'h02);
          end
        end
      end
      H_POST: begin
        if (bit_end) begin
          if (cnt_reg == 3'h1) begin
            st_next = H_IDLE;
            rsp_next = 1'h1;
            rdat_next = sh_reg;
          end else begin
            cnt_next = 3'h1;
            tms_next = 1'h0;
          end
        end
      end
      default: st_next = H_IDLE;
    endcase
    // Clock stands still low between commands.
    tck_next = (st_next != H_IDLE) && (div_next >= DIV_HIGH);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= H_IDLE;
      div_reg <= 3'h0;
      tck_reg <= 1'h0;
      tms_reg <= 1'h0;
      tdi_reg <= 1'h0;
      pat_reg <= 6'h00;
      cnt_reg <= 3'h0;
      len_reg <= LEN_BYP;
      left_reg <= LEN_BYP;
      sh_reg <= 32'h0000_0000;
      rst_op_reg <= 1'h0;
      rsp_reg <= 1'h0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
      div_reg <= div_next;
      tck_reg <= tck_next;
      tms_reg <= tms_next;
      tdi_reg <= tdi_next;
      pat_reg <= pat_next;
      cnt_reg <= cnt_next;
      len_reg <= len_next;
      left_reg <= left_next;
      sh_reg <= sh_next;
      rst_op_reg <= rst_op_next;
      rsp_reg <= rsp_next;
      rdat_reg <= rdat_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; the reset line is open drain, so only a pull-low is driven.
  assign cmd_ready = (st_reg == H_IDLE);
  assign rsp_valid = rsp_reg;
  assign rsp_data = rdat_reg;
  assign link.tck = tck_reg;
  assign link.tms = tms_reg;
  assign link.tdi = tdi_reg;
  assign link.host_rst_oe = sys_rst_req;
  assign sys_rst_seen = ins[1];
endmodule // tap_host

// [testbench/tap_link_asserts.sv]
// Checker watching the test link between the controller and the device.
`timescale 1ns/1ps
module tap_link_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo_o,
  input wire logic tdo_oe,
  input wire logic pull_en
);
  import tap_pkg::*;

  tap_state_e st_reg, st_next; // Tracked controller state.
  logic [2:0] ones_reg, ones_next; // Run of TMS-high edges, saturating at five.
  logic [2:0] ir_cnt_reg, ir_cnt_next; // Edges spent in Shift-IR.
  logic trk_reg, trk_next; // Tracking is trusted only after a reset walk.

  ////////////////////////////////////////////////////////////////////////////
  // Next values; a run of five highs wins whatever the tracked state is.
  always_comb begin
    ones_next = tms ? ((ones_reg == 3'h5) ? ones_reg : ones_reg + 3'h1) : 3'h0;
    trk_next = pull_en & (trk_reg | (ones_next == 3'h5));
    ir_cnt_next = (st_reg == ST_SH_IR) ? ir_cnt_reg + 3'h1 : 3'h0;
    case (st_reg)
      ST_RESET: st_next = tms ? ST_RESET : ST_IDLE;
      ST_IDLE, ST_UPD_DR, ST_UPD_IR: st_next = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: st_next = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR, ST_SH_DR: st_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: st_next = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: st_next = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: st_next = tms ? ST_UPD_DR : ST_SH_DR;
      ST_SEL_IR: st_next = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR, ST_SH_IR: st_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: st_next = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: st_next = tms ? ST_EX2_IR : ST_PAU_IR;
      default: st_next = tms ? ST_UPD_IR : ST_SH_IR;
    endcase
    if (ones_next == 3'h5) begin
      st_next = ST_RESET;
    end
  end

  // Registers of the tracker, stepped by the link clock.
  always_ff @(posedge tck or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= ST_RESET;
      ones_reg <= 3'h0;
      ir_cnt_reg <= 3'h0;
      trk_reg <= 1'h0;
    end else begin
      st_reg <= st_next;
      ones_reg <= ones_next;
      ir_cnt_reg <= ir_cnt_next;
      trk_reg <= trk_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  tdo_only_shift_a: assert property (@(posedge tck) disable iff (!arst_n)
    tdo_oe && pull_en && trk_reg |-> (st_reg == ST_SH_DR || st_reg == ST_SH_IR))
    else $error("tdo driven outside a shift state");
  tdo_on_fall_a: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(tdo_o) && tdo_oe && trk_reg |-> !tck)
    else $error("tdo changed while tck high");
  tck_high_span_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(tck) |-> tck [*4] ##1 !tck)
    else $error("tck high phase not four cycles");
  tms_setup_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(tck) |-> $stable(tms) && $stable(tdi))
    else $error("tms or tdi moved at rising tck");
  ir_capture_out_a: assert property (@(posedge tck) disable iff (!arst_n)
    trk_reg && tdo_oe && st_reg == ST_SH_IR && ir_cnt_reg < 3'h4 |-> tdo_o == (ir_cnt_reg == 3'h0))
    else $error("captured instruction bits wrong");
  five_high_reset_a: assert property (@(posedge tck) disable iff (!arst_n)
    ones_reg == 3'h5 && pull_en |-> !tdo_oe)
    else $error("tdo driven after five high edges");
  ir_four_bits_a: assert property (@(posedge tck) disable iff (!arst_n)
    trk_reg && st_reg == ST_SH_IR && tms |-> ir_cnt_reg == 3'h3)
    else $error("instruction shift not four bits");
  update_home_a: assert property (@(posedge tck) disable iff (!arst_n)
    trk_reg && (st_reg == ST_UPD_IR || st_reg == ST_UPD_DR) |-> !tms)
    else $error("walk from update not to idle");
  capture_to_shift_a: assert property (@(posedge tck) disable iff (!arst_n)
    trk_reg && st_reg == ST_CAP_DR |-> !tms)
    else $error("capture not followed by shift");
endmodule // tap_link_asserts

// [testbench/jtag_tap_controller_bench.sv]
// Bench joining the controller end and the device end over the test link.
`timescale 1ns/1ps
module jtag_tap_controller_bench;
  import tap_pkg::*;
  typedef struct {tap_op_e op; logic [5:0] len; logic [31:0] data; logic [31:0] exp;} tap_row_s;
  logic clk, arst_n, fuse, dis, dbg, gpio_out, gpio_oe, rst_drive, rst_req, cmd_valid;
  logic run_idle, port_active, cmd_ready, rsp_valid, rst_seen, pin_tms, pin_tdi; // Design outputs.
  logic [7:0] bsc_out, iscan_out, brk_out;
  logic [15:0] prog_out;
  logic [3:0] instr;
  logic [31:0] rsp_data, cmd_data, got; // Got holds the masked answer.
  logic [5:0] cmd_len;
  tap_op_e cmd_op;
  int err_count, comparisons;
  tap_row_s rows [14]; // Ordinary transfers with their expected answers.

  tap_link_if i_tap_link_if ();
  tap_device i_tap_device (.arst_n(arst_n), .link(i_tap_link_if.dev),
    .test_port_enable_fuse(fuse), .test_port_disable_bit(dis), .debug_enable_fuse(dbg),
    .bsc_in(8'h5A), .bsc_out(bsc_out), .prog_in(16'hC3A5), .prog_out(prog_out),
    .iscan_in(8'h96), .iscan_out(iscan_out), .brk_in(8'h69), .brk_out(brk_out),
    .instr(instr), .run_idle(run_idle), .port_active(port_active), .pin_tms(pin_tms),
    .pin_tdi(pin_tdi), .gpio_tdo_out(gpio_out), .gpio_tdo_oe(gpio_oe),
    .sys_reset_drive(rst_drive));
  tap_host i_tap_host (.clk(clk), .arst_n(arst_n), .link(i_tap_link_if.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_len(cmd_len),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .sys_rst_req(rst_req), .sys_rst_seen(rst_seen));
  tap_link_asserts i_tap_link_asserts (.clk(clk), .arst_n(arst_n), .tck(i_tap_link_if.tck),
    .tms(i_tap_link_if.tms), .tdi(i_tap_link_if.tdi), .tdo_o(i_tap_link_if.tdo_o),
    .tdo_oe(i_tap_link_if.tdo_oe), .pull_en(i_tap_link_if.pull_en));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, count and report.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One command; the answer is masked to its length since upper bits are leftovers.
  task automatic run_cmd(input tap_op_e op, input logic [5:0] len, input logic [31:0] data);
    int n;
    n = 0;
    @(negedge clk);
    cmd_op = op;
    cmd_len = len;
    cmd_data = data;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (op != OP_RESET && rsp_valid !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    got = rsp_data & (32'hFFFF_FFFF >> (6'h20 - len));
    while (cmd_ready !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check(32'(n >= 4000), 32'h0);
  endtask

  // Single place where the run ends.
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // System clock, 50 ns period.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Watchdog: the tests need well under half of this span.
  initial begin
    #2000000;
    err_count++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {arst_n, dis, gpio_out, gpio_oe, rst_drive, rst_req, cmd_valid} = 7'h00;
    {fuse, dbg} = 2'h3;
    cmd_op = OP_RESET;
    {cmd_len, cmd_data, err_count, comparisons} = '0;
    rows = '{'{OP_IR, 6'h04, 32'h1, 32'h1}, '{OP_DR, 6'h20, 32'h0, ID_VALUE},
      '{OP_IR, 6'h04, 32'hF, 32'h1}, '{OP_DR, 6'h08, 32'hA5, 32'h4A},
      '{OP_IR, 6'h04, 32'h0, 32'h1}, '{OP_DR, 6'h08, 32'h3C, 32'h5A},
      '{OP_IR, 6'h04, 32'h2, 32'h1}, '{OP_DR, 6'h08, 32'hC3, 32'h5A},
      '{OP_IR, 6'h04, 32'h4, 32'h1}, '{OP_DR, 6'h10, 32'h1234, 32'hC3A5},
      '{OP_IR, 6'h04, 32'h8, 32'h1}, '{OP_DR, 6'h08, 32'h81, 32'h96},
      '{OP_IR, 6'h04, 32'hB, 32'h1}, '{OP_DR, 6'h08, 32'h7E, 32'h69}};
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    run_cmd(OP_RESET, 6'h06, 32'h0);
    check(32'(instr), 32'(INS_RESET_VAL));
    foreach (rows[i]) begin
      run_cmd(rows[i].op, rows[i].len, rows[i].data);
      check(got, rows[i].exp);
      if (rows[i].op == OP_IR) begin
        check(32'(instr), rows[i].data);
      end
    end
    // Latched outputs keep the last update; the sample pass must not touch them.
    check(32'(bsc_out), 32'h3C);
    check(32'(prog_out), 32'h1234);
    check(32'({iscan_out, brk_out}), 32'h817E);
    check(32'(run_idle), 32'h1);
    // Private codes fall back to bypass without the debug fuse.
    dbg = 1'b0;
    run_cmd(OP_IR, 6'h04, 32'h9);
    run_cmd(OP_DR, 6'h08, 32'hA5);
    check(got, 32'h4A);
    run_cmd(OP_IR, 6'h04, 32'hA);
    run_cmd(OP_DR, 6'h08, 32'hA5);
    check(got, 32'h4A);
    dbg = 1'b1;
    run_cmd(OP_RESET, 6'h06, 32'h0);
    check(32'(instr), 32'(INS_RESET_VAL));
    // Disable bit: controller held, released tdo reads high.
    dis = 1'b1;
    run_cmd(OP_RESET, 6'h06, 32'h0);
    check(32'(port_active), 32'h0);
    run_cmd(OP_IR, 6'h04, 32'hF);
    check(got, 32'hF);
    // Fuse off: pins plain, tdo follows the general-purpose logic.
    {dis, fuse} = 2'h0;
    run_cmd(OP_RESET, 6'h06, 32'h0);
    check(32'({port_active, i_tap_link_if.pull_en}), 32'h0);
    // Raise gpio_oe once the fuse has crossed: until then pull_en still reads high.
    gpio_oe = 1'b1;
    run_cmd(OP_IR, 6'h04, 32'hF);
    check(got, 32'h0);
    {fuse, gpio_oe} = 2'h2;
    run_cmd(OP_RESET, 6'h06, 32'h0);
    check(32'({port_active, i_tap_link_if.pull_en}), 32'h3);
    // Open-drain system reset seen from either side.
    rst_req = 1'b1;
    for (int n = 0; n < 20 && rst_seen !== 1'b1; n++) @(negedge clk);
    check(32'(rst_seen), 32'h1);
    {rst_req, rst_drive} = 2'h1;
    repeat (6) @(negedge clk);
    check(32'(rst_seen), 32'h1);
    rst_drive = 1'b0;
    // Power-on reset in mid transfer returns to the reset instruction.
    run_cmd(OP_IR, 6'h04, 32'hF);
    fork
      run_cmd(OP_DR, 6'h20, 32'hFFFF_FFFF);
      repeat (100) @(negedge clk);
    join_any
    disable fork;
    check(32'({pin_tms, pin_tdi}), 32'h1);
    arst_n = 1'b0;
    @(negedge clk);
    arst_n = 1'b1;
    check(32'(instr), 32'(INS_RESET_VAL));
    run_cmd(OP_RESET, 6'h06, 32'h0);
    run_cmd(OP_DR, 6'h20, 32'h0);
    check(got, ID_VALUE);
    end_of_test();
  end
endmodule // jtag_tap_controller_bench
